// ===== core/bscan_host.sv
// scan controller end: fifo of commands, tck divider, tms/tdi sequencer
// assumes commands arrive on core_clk; tdo is asynchronous to it
`timescale 1ns/1ns
module bscan_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] count;
    } fifo_state_t;

    fifo_state_t cur;
    fifo_state_t next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    assign in_ready = (cur.count != (AW+1)'(DEPTH));
    assign out_valid = (cur.count != '0);
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = mem[cur.rd];

    // pointer and fill level update
    always_comb begin
        next = cur;
        if (push) begin
            next.wr = cur.wr + 1'h1;
        end
        if (pop) begin
            next.rd = cur.rd + 1'h1;
        end
        next.count = cur.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cur <= '0;
        end else begin
            cur <= next;
        end
    end

    // storage written on push only
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[cur.wr] <= in_data;
        end
    end
endmodule

module bscan_host (
    input wire logic core_clk,
    input wire logic rst,
    tap_link_if.host link,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [bscan_pkg::CMD_W-1:0] cmd_word,
    output logic result_valid,
    output logic result_bit,
    output logic result_last,
    output logic busy
);
    import bscan_pkg::*;

    typedef enum logic [2:0] {
        H_IDLE, H_RESET, H_PRE, H_SHIFT, H_POST
    } host_phase_t;

    typedef struct packed {
        host_phase_t phase;
        logic [DIV_W-1:0] div;
        logic tck;
        logic tms;
        logic tdi;
        logic drv_oe;
        logic is_ir;
        logic [CNT_W-1:0] cnt;
        logic [IR_LEN-1:0] ir_sh;
        logic [IR_LEN-1:0] dev_ir;
        logic tdo_s1;
        logic tdo_s2;
        logic res_valid;
        logic res_bit;
        logic res_last;
    } host_state_t;

    localparam int TCK_HALF_MIN = (TCK_MIN_PERIOD_NS / 2 + CORE_CLK_NS - 1)
                                  / CORE_CLK_NS;
    localparam int HALF = (TCK_HALF_CYCLES > TCK_HALF_MIN) ?
                          TCK_HALF_CYCLES : TCK_HALF_MIN;

    host_state_t cur;
    host_state_t next;
    logic q_valid;
    logic q_ready;
    logic [CMD_W-1:0] q_word;
    logic edge_due;
    logic rise;
    logic fall;
    logic stall;
    logic [CNT_W-1:0] len;
    logic [CNT_W-1:0] pre_len;

    bscan_fifo #(.WIDTH(CMD_W), .DEPTH(FIFO_DEPTH)) cmd_q (
        .core_clk(core_clk),
        .rst(rst),
        .in_valid(cmd_valid),
        .in_ready(cmd_ready),
        .in_data(cmd_word),
        .out_valid(q_valid),
        .out_ready(q_ready),
        .out_data(q_word)
    );

    // scan lengths follow the loaded instruction
    assign pre_len = cur.is_ir ? CNT_W'(PRE_LEN_IR) : CNT_W'(PRE_LEN_DR);
    always_comb begin
        if (cur.is_ir) begin
            len = CNT_W'(IR_LEN);
        end else if (cur.dev_ir == OP_SAMPLE || cur.dev_ir == OP_EXTEST) begin
            len = CNT_W'(BSR_LEN);
        end else begin
            len = CNT_W'(1);
        end
    end

    // tck divider; the fall before a data bit waits for fifo data
    assign edge_due = (cur.div == DIV_W'(HALF - 1));
    assign stall = cur.tck & (cur.phase == H_SHIFT) & ~cur.is_ir & ~q_valid;
    assign rise = edge_due & ~cur.tck;
    assign fall = edge_due & cur.tck & ~stall;
    assign q_ready = (rise & (cur.phase == H_IDLE)) |
                     (fall & (cur.phase == H_SHIFT) & ~cur.is_ir);

    always_comb begin
        next = cur;
        next.drv_oe = 1'h1;
        next.tdo_s1 = link.tdo;
        next.tdo_s2 = cur.tdo_s1;
        next.res_valid = 1'h0;
        if (~(edge_due & cur.tck & stall)) begin
            next.div = edge_due ? '0 : cur.div + 1'h1;
        end
        if (rise | fall) begin
            next.tck = ~cur.tck;
        end
        // falling edge: set tms and tdi for the coming rising edge
        if (fall) begin
            case (cur.phase)
                H_IDLE: next.tms = 1'h0;
                H_RESET: next.tms = 1'h1;
                H_PRE: next.tms = (cur.cnt == '0) |
                                  (cur.is_ir & (cur.cnt == CNT_W'(1)));
                H_SHIFT: begin
                    next.tms = (cur.cnt == len - 1'h1);
                    next.tdi = cur.is_ir ? cur.ir_sh[0] : q_word[CMD_BIT];
                end
                H_POST: next.tms = (cur.cnt == '0);
                default: next.tms = 1'h1;
            endcase
        end
        // rising edge: device samples, host advances and reads tdo
        if (rise) begin
            case (cur.phase)
                H_IDLE: begin
                    next.cnt = '0;
                    if (q_valid) begin
                        next.is_ir =
                            (q_word[CMD_KIND_HI:CMD_KIND_LO] == CMD_IR);
                        case (q_word[CMD_KIND_HI:CMD_KIND_LO])
                            CMD_RESET: begin
                                next.phase = H_RESET;
                                next.dev_ir = OP_BYPASS;
                            end
                            CMD_IR: begin
                                next.phase = H_PRE;
                                next.ir_sh = q_word[CMD_OP_HI:0];
                                next.dev_ir = q_word[CMD_OP_HI:0];
                            end
                            CMD_DR: next.phase = H_PRE;
                            default: next.phase = H_IDLE;
                        endcase
                    end
                end
                H_RESET: begin
                    next.cnt = cur.cnt + 1'h1;
                    if (cur.cnt == CNT_W'(RESET_TMS_ONES - 1)) begin
                        next.phase = H_POST;
                        next.cnt = CNT_W'(1);
                    end
                end
                H_PRE: begin
                    next.cnt = cur.cnt + 1'h1;
                    if (cur.cnt == pre_len - 1'h1) begin
                        next.phase = H_SHIFT;
                        next.cnt = '0;
                    end
                end
                H_SHIFT: begin
                    next.res_valid = 1'h1;
                    next.res_bit = cur.tdo_s2;
                    next.res_last = (cur.cnt == len - 1'h1);
                    next.ir_sh = {1'h0, cur.ir_sh[IR_LEN-1:1]};
                    next.cnt = cur.cnt + 1'h1;
                    if (cur.cnt == len - 1'h1) begin
                        next.phase = H_POST;
                        next.cnt = '0;
                    end
                end
                H_POST: begin
                    next.cnt = cur.cnt + 1'h1;
                    if (cur.cnt == CNT_W'(POST_LEN - 1)) begin
                        next.phase = H_IDLE;
                    end
                end
                default: next.phase = H_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cur <= '0;
            cur.dev_ir <= OP_BYPASS;
        end else begin
            cur <= next;
        end
    end

    assign link.tck = cur.tck;
    assign link.tms_drv = cur.tms;
    assign link.tdi_drv = cur.tdi;
    assign link.drv_oe = cur.drv_oe;
    assign result_valid = cur.res_valid;
    assign result_bit = cur.res_bit;
    assign result_last = cur.res_last;
    assign busy = (cur.phase != H_IDLE) | q_valid;
endmodule

// ===== core/bscan_pkg.sv
// constants and types shared by both ends of the boundary-scan test link
// assumes nothing beyond a SystemVerilog compiler
package bscan_pkg;

    // instruction register
    localparam int IR_LEN = 3;
    localparam logic [IR_LEN-1:0] OP_EXTEST = 3'h0;
    localparam logic [IR_LEN-1:0] OP_SAMPLE = 3'h5;
    localparam logic [IR_LEN-1:0] OP_BYPASS = 3'h7;
    localparam logic [IR_LEN-1:0] IR_CAPTURE = 3'h1;

    // boundary register length per variant; this build uses the first
    localparam int BSR_LEN_SMALL = 522;
    localparam int BSR_LEN_MID = 621;
    localparam int BSR_LEN_LARGE = 666;
    localparam int BSR_LEN = BSR_LEN_SMALL;

    // host timing and sequencing
    localparam int CORE_CLK_NS = 100;
    localparam int TCK_MIN_PERIOD_NS = 100;
    localparam int TCK_HALF_CYCLES = 4;
    localparam int RESET_TMS_ONES = 5;
    localparam int PRE_LEN_IR = 4;
    localparam int PRE_LEN_DR = 3;
    localparam int POST_LEN = 2;
    localparam int CNT_W = 10;
    localparam int DIV_W = 3;

    // command word carried by the host fifo
    localparam int FIFO_DEPTH = 32;
    localparam int CMD_W = 16;
    localparam int CMD_KIND_HI = 15;
    localparam int CMD_KIND_LO = 14;
    localparam int CMD_OP_HI = 2;
    localparam int CMD_BIT = 0;
    localparam logic [1:0] CMD_DATA = 2'h0;
    localparam logic [1:0] CMD_IR = 2'h1;
    localparam logic [1:0] CMD_DR = 2'h2;
    localparam logic [1:0] CMD_RESET = 2'h3;

    // sixteen-state test access port controller
    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR,
        PAUSE_DR, EXIT2_DR, UPD_DR, SEL_IR, CAP_IR, SHIFT_IR,
        EXIT1_IR, PAUSE_IR, EXIT2_IR, UPD_IR
    } tap_state_t;

endpackage

// ===== core/tap_link_if.sv
// test access port wires between the scan controller and the device
// assumes the host makes tck; pulls resolve undriven pins to one
`timescale 1ns/1ns
interface tap_link_if;
    logic tck;
    logic tms_drv;
    logic tdi_drv;
    logic drv_oe;
    logic tdo_drv;
    logic tdo_oe;
    logic tms;
    logic tdi;
    logic tdo;

    // weak pull-ups on the test inputs, bench pull on the test output
    assign tms = drv_oe ? tms_drv : 1'h1;
    assign tdi = drv_oe ? tdi_drv : 1'h1;
    assign tdo = tdo_oe ? tdo_drv : 1'h1;

    modport device (input tck, input tms, input tdi,
                    output tdo_drv, output tdo_oe);
    modport host (output tck, output tms_drv, output tdi_drv,
                  output drv_oe, input tdo);
endinterface

// ===== core/bscan_device.sv
// boundary-scan test port of the device, clocked by the link tck
// assumes pin levels and core outputs are asynchronous to tck
//
// Summary of operation
// - standard instructions, registers and port behaviour
// - no scans while configuring unless port disabled
// - sample captures pins, preloads pattern, no disturbance
// - external test drives pattern, captures input pins
// - bypass is one-bit register, one clock delay
// - instruction register is exactly three bits
// - boundary register length 522, 621 or 666
// - test inputs have weak pull-ups
`timescale 1ns/1ns
module bscan_device (
    input wire logic rst,
    tap_link_if.device link,
    input wire logic config_busy,
    input wire logic scan_off_user,
    input wire logic [bscan_pkg::BSR_LEN-1:0] pin_level,
    input wire logic [bscan_pkg::BSR_LEN-1:0] core_out,
    output logic [bscan_pkg::BSR_LEN-1:0] pin_out,
    output logic extest_active
);
    import bscan_pkg::*;

    typedef struct packed {
        tap_state_t tap;
        logic [IR_LEN-1:0] ir;
        logic [IR_LEN-1:0] ir_sr;
        logic bypass;
        logic [BSR_LEN-1:0] bsr_sr;
        logic [BSR_LEN-1:0] bsr_upd;
        logic [BSR_LEN-1:0] lvl_s1;
        logic [BSR_LEN-1:0] lvl_s2;
        logic [BSR_LEN-1:0] core_s1;
        logic [BSR_LEN-1:0] core_s2;
        logic [BSR_LEN-1:0] pin_out;
        logic cfg_s1;
        logic cfg_s2;
        logic off_s1;
        logic off_s2;
    } dev_state_t;

    dev_state_t cur;
    dev_state_t next;
    logic bsr_sel;
    logic ext_mode;
    logic scan_barred;
    logic tdo_q;
    logic tdo_oe_q;

    // standard controller walk on the sampled tms
    function automatic tap_state_t tap_next(input tap_state_t s,
                                            input logic tms);
        tap_state_t n;
        n = s;
        case (s)
            TAP_RESET: n = tms ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: n = tms ? SEL_DR : TAP_IDLE;
            SEL_DR: n = tms ? SEL_IR : CAP_DR;
            CAP_DR: n = tms ? EXIT1_DR : SHIFT_DR;
            SHIFT_DR: n = tms ? EXIT1_DR : SHIFT_DR;
            EXIT1_DR: n = tms ? UPD_DR : PAUSE_DR;
            PAUSE_DR: n = tms ? EXIT2_DR : PAUSE_DR;
            EXIT2_DR: n = tms ? UPD_DR : SHIFT_DR;
            UPD_DR: n = tms ? SEL_DR : TAP_IDLE;
            SEL_IR: n = tms ? TAP_RESET : CAP_IR;
            CAP_IR: n = tms ? EXIT1_IR : SHIFT_IR;
            SHIFT_IR: n = tms ? EXIT1_IR : SHIFT_IR;
            EXIT1_IR: n = tms ? UPD_IR : PAUSE_IR;
            PAUSE_IR: n = tms ? EXIT2_IR : PAUSE_IR;
            EXIT2_IR: n = tms ? UPD_IR : SHIFT_IR;
            UPD_IR: n = tms ? SEL_DR : TAP_IDLE;
            default: n = TAP_RESET;
        endcase
        return n;
    endfunction

    // instruction decode; unknown codes select the bypass bit
    assign bsr_sel = (cur.ir == OP_SAMPLE) || (cur.ir == OP_EXTEST);
    assign ext_mode = (cur.ir == OP_EXTEST);
    assign scan_barred = cur.cfg_s2 & ~cur.off_s2;

    // next state of the whole port
    always_comb begin
        next = cur;
        next.lvl_s1 = pin_level;
        next.lvl_s2 = cur.lvl_s1;
        next.core_s1 = core_out;
        next.core_s2 = cur.core_s1;
        next.cfg_s1 = config_busy;
        next.cfg_s2 = cur.cfg_s1;
        next.off_s1 = scan_off_user;
        next.off_s2 = cur.off_s1;
        // held in reset while configuration runs, unless scan_off_user is set
        if (scan_barred) begin
            next.tap = TAP_RESET;
        end else begin
            next.tap = tap_next(cur.tap, link.tms);
        end
        case (cur.tap)
            TAP_RESET: begin
                next.ir = OP_BYPASS;
            end
            CAP_IR: begin
                next.ir_sr = IR_CAPTURE;
            end
            SHIFT_IR: begin
                next.ir_sr = {link.tdi, cur.ir_sr[IR_LEN-1:1]};
            end
            UPD_IR: begin
                next.ir = cur.ir_sr;
            end
            CAP_DR: begin
                if (bsr_sel) begin
                    next.bsr_sr = cur.lvl_s2;
                end else begin
                    next.bypass = 1'h0;
                end
            end
            SHIFT_DR: begin
                if (bsr_sel) begin
                    next.bsr_sr = {link.tdi, cur.bsr_sr[BSR_LEN-1:1]};
                end else begin
                    next.bypass = link.tdi;
                end
            end
            UPD_DR: begin
                if (bsr_sel) begin
                    next.bsr_upd = cur.bsr_sr;
                end
            end
            default: begin
            end
        endcase
        // pattern reaches the pins only under external test
        next.pin_out = ext_mode ? cur.bsr_upd : cur.core_s2;
    end

    // state register on the rising test clock
    always_ff @(posedge link.tck or posedge rst) begin
        if (rst) begin
            cur <= '0;
            cur.ir <= OP_BYPASS;
        end else begin
            cur <= next;
        end
    end

    // test output changes on the falling edge, driven in shift only
    always_ff @(negedge link.tck or posedge rst) begin
        if (rst) begin
            tdo_q <= 1'h0;
            tdo_oe_q <= 1'h0;
        end else begin
            tdo_oe_q <= (cur.tap == SHIFT_IR) || (cur.tap == SHIFT_DR);
            if (cur.tap == SHIFT_IR) begin
                tdo_q <= cur.ir_sr[0];
            end else if (bsr_sel) begin
                tdo_q <= cur.bsr_sr[0];
            end else begin
                tdo_q <= cur.bypass;
            end
        end
    end

    // pull-ups on tms and tdi live where the wire is resolved
    assign link.tdo_drv = tdo_q;
    assign link.tdo_oe = tdo_oe_q;
    assign pin_out = cur.pin_out;
    assign extest_active = ext_mode;
endmodule

// ===== sim/bscan_link_checker.sv
// checker watching the test link between the scan controller and device
// assumes tck is made by the host from core_clk; rst is shared
`timescale 1ns/1ns
module bscan_link_checker (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic tms_drv,
    input wire logic tdi_drv,
    input wire logic tdo_drv,
    input wire logic tdo_oe,
    input wire logic tdo,
    input wire logic config_busy,
    input wire logic scan_off_user
);
    import bscan_pkg::*;
    tap_state_t st;
    logic [IR_LEN-1:0] ir_sh;
    logic [IR_LEN-1:0] ir;
    logic [CNT_W-1:0] n_sh;
    logic [CNT_W-1:0] dr_len;
    logic desync;

    // next controller state from tms
    function automatic tap_state_t step(tap_state_t s, logic m);
        case (s)
            TAP_RESET: step = m ? TAP_RESET : TAP_IDLE;
            TAP_IDLE, UPD_DR, UPD_IR: step = m ? SEL_DR : TAP_IDLE;
            SEL_DR: step = m ? SEL_IR : CAP_DR;
            CAP_DR, SHIFT_DR: step = m ? EXIT1_DR : SHIFT_DR;
            EXIT1_DR: step = m ? UPD_DR : PAUSE_DR;
            PAUSE_DR: step = m ? EXIT2_DR : PAUSE_DR;
            EXIT2_DR: step = m ? UPD_DR : SHIFT_DR;
            SEL_IR: step = m ? TAP_RESET : CAP_IR;
            CAP_IR, SHIFT_IR: step = m ? EXIT1_IR : SHIFT_IR;
            EXIT1_IR: step = m ? UPD_IR : PAUSE_IR;
            PAUSE_IR: step = m ? EXIT2_IR : PAUSE_IR;
            default: step = m ? UPD_IR : SHIFT_IR;
        endcase
    endfunction

    assign dr_len = (ir == OP_SAMPLE || ir == OP_EXTEST) ? CNT_W'(BSR_LEN)
                                                        : CNT_W'(1);

    // shadow of the controller, instruction and shift count; desync marks
    // a barred stretch in which the device ignores the wires
    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            st <= TAP_RESET;
            ir_sh <= '0;
            ir <= OP_BYPASS;
            n_sh <= '0;
            desync <= 1'b0;
        end else begin
            st <= step(st, tms);
            if (st == SHIFT_IR)
                ir_sh <= {tdi, ir_sh[IR_LEN-1:1]};
            if (st == TAP_RESET)
                ir <= OP_BYPASS;
            else if (st == UPD_IR)
                ir <= ir_sh;
            if (st == CAP_IR || st == CAP_DR)
                n_sh <= '0;
            else if (st == SHIFT_IR || st == SHIFT_DR)
                n_sh <= n_sh + 1'b1;
            if (config_busy && !scan_off_user)
                desync <= 1'b1;
            else if (st == TAP_RESET)
                desync <= 1'b0;
        end
    end

    a_tdo_oe_shift: assert property (
        @(posedge tck) disable iff (rst || desync)
        tdo_oe == (st == SHIFT_IR || st == SHIFT_DR))
        else $error("tdo enable outside shift states");
    a_ir_capture_bits: assert property (
        @(posedge tck) disable iff (rst || desync)
        (st == SHIFT_IR && $past(st) == CAP_IR) |-> tdo == IR_CAPTURE[0]
        ##1 tdo == IR_CAPTURE[1] ##1 tdo == IR_CAPTURE[2])
        else $error("wrong instruction capture bits");
    a_bypass_capture: assert property (
        @(posedge tck) disable iff (rst || desync)
        (st == SHIFT_DR && $past(st) == CAP_DR && ir == OP_BYPASS)
        |-> tdo == 1'b0)
        else $error("bypass bit not captured as zero");
    a_ir_scan_length: assert property (
        @(posedge tck) disable iff (rst) st == UPD_IR |-> n_sh == IR_LEN)
        else $error("instruction scan length wrong");
    a_dr_scan_length: assert property (
        @(posedge tck) disable iff (rst) st == UPD_DR |-> n_sh == dr_len)
        else $error("data scan length wrong");
    a_tck_high_time: assert property (
        @(posedge core_clk) disable iff (rst) $rose(tck) |-> tck [*4])
        else $error("tck high phase too short");
    a_tck_low_time: assert property (
        @(posedge core_clk) disable iff (rst)
        $fell(tck) |-> !tck [*4] ##1 tck)
        else $error("tck low phase not four cycles");
    a_tdo_on_fall: assert property (
        @(posedge core_clk) disable iff (rst || desync)
        ($changed(tdo_drv) || $changed(tdo_oe)) |-> !tck)
        else $error("tdo moved while tck high");
    a_tms_on_fall: assert property (
        @(posedge core_clk) disable iff (rst)
        ($changed(tms_drv) || $changed(tdi_drv)) |-> !tck)
        else $error("tms or tdi moved while tck high");
endmodule

// ===== sim/test_boundary_scan_test_port.sv
// bench joining host and device over the link, results against a model
// assumes the host derives tck from core_clk; no other clock is made
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
    $display("mismatch at %0t got %h exp %h", $time, g, e); end end
module test_boundary_scan_test_port;
    import bscan_pkg::*;
    logic core_clk = 0, rst = 1, cmd_valid = 0, saw_full = 0;
    logic config_busy = 0, scan_off_user = 0;
    logic [CMD_W-1:0] cmd_word = '0;
    logic [BSR_LEN-1:0] pin_level = '0, core_out = '0, pin_out, pat, pre;
    logic cmd_ready, result_valid, result_bit, result_last, busy;
    logic extest_active;
    int mismatches = 0, n_tests = 0;
    logic exp_bit[$], got_bit[$], exp_last[$], got_last[$];

    always #50 core_clk = ~core_clk;

    tap_link_if link();
    bscan_host u_bscan_host(.core_clk(core_clk), .rst(rst), .link(link),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_word(cmd_word),
        .result_valid(result_valid), .result_bit(result_bit),
        .result_last(result_last), .busy(busy));
    bscan_device u_bscan_device(.rst(rst), .link(link),
        .config_busy(config_busy), .scan_off_user(scan_off_user),
        .pin_level(pin_level), .core_out(core_out), .pin_out(pin_out),
        .extest_active(extest_active));
    bscan_link_checker u_bscan_link_checker(.core_clk(core_clk), .rst(rst),
        .tck(link.tck), .tms(link.tms), .tdi(link.tdi),
        .tms_drv(link.tms_drv), .tdi_drv(link.tdi_drv),
        .tdo_drv(link.tdo_drv), .tdo_oe(link.tdo_oe), .tdo(link.tdo),
        .config_busy(config_busy), .scan_off_user(scan_off_user));

    // collect results and note a refusing fifo
    always @(posedge core_clk) begin
        if (result_valid === 1'b1) begin
            got_bit.push_back(result_bit);
            got_last.push_back(result_last);
        end
        if (cmd_ready === 1'b0 && rst === 1'b0)
            saw_full <= 1'b1;
    end

    task tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    function automatic logic [BSR_LEN-1:0] rnd();
        logic [BSR_LEN-1:0] v;
        for (int i = 0; i < BSR_LEN; i++)
            v[i] = 1'($urandom());
        return v;
    endfunction

    // one command word, held until the fifo takes it
    task push(input logic [1:0] kind, input logic [2:0] val);
        int n;
        n = 0;
        cmd_valid <= 1'b1;
        cmd_word <= {kind, 11'h000, val};
        do begin
            @(posedge core_clk);
            n++;
        end while (cmd_ready !== 1'b1 && n < 10000);
        if (n >= 10000) begin
            mismatches++;
            tally_and_finish();
        end
    endtask

    // instruction scan; a barred device leaves tdo pulled high
    task scan_ir(input logic [2:0] op, input logic barred);
        push(CMD_IR, op);
        for (int i = 0; i < IR_LEN; i++) begin
            exp_bit.push_back(barred ? 1'b1 : IR_CAPTURE[i]);
            exp_last.push_back(i == IR_LEN - 1);
        end
    endtask

    // data scan of n bits, lsb first; slow leaves gaps that stall tck
    task scan_dr(input int n, input logic [BSR_LEN-1:0] v, input logic slow);
        push(CMD_DR, 3'h0);
        for (int i = 0; i < n; i++) begin
            push(CMD_DATA, {2'h0, v[i]});
            if (slow) begin
                cmd_valid <= 1'b0;
                repeat (1 + $urandom() % 20) @(posedge core_clk);
            end
            exp_bit.push_back(n == 1 ? 1'b0 : pin_level[i]);
            exp_last.push_back(i == n - 1);
        end
    endtask

    // wait for the sequencer to drain, then compare every result
    task finish_batch(input string name);
        int n;
        logic g, e;
        n = 0;
        cmd_valid <= 1'b0;
        do begin
            @(posedge core_clk);
            n++;
        end while ((busy !== 1'b0 || got_bit.size() < exp_bit.size())
                   && n < 20000);
        if (n >= 20000) begin
            mismatches++;
            tally_and_finish();
        end
        // the pin register follows the update register one tck later
        repeat (4 * TCK_HALF_CYCLES) @(posedge core_clk);
        `CHK(got_bit.size(), exp_bit.size())
        while (exp_bit.size() > 0 && got_bit.size() > 0) begin
            g = got_bit.pop_front();
            e = exp_bit.pop_front();
            `CHK(g, e)
            g = got_last.pop_front();
            e = exp_last.pop_front();
            `CHK(g, e)
        end
        got_bit.delete();
        got_last.delete();
        exp_bit.delete();
        exp_last.delete();
        $display("test %s done", name);
    endtask

    initial begin
        void'($urandom(65944));
        pin_level <= rnd();
        core_out <= rnd();
        repeat (12) @(posedge core_clk);
        // undriven test inputs must read as one while the host is in reset
        `CHK(link.tms & link.tdi, 1'b1)
        rst <= 1'b0;
        @(posedge core_clk);
        push(CMD_RESET, 3'h0);
        // every opcode, followed by a data scan of its length
        for (int op = 0; op < 8; op++) begin
            pat = rnd();
            pin_level <= rnd();
            scan_ir(3'(op), 1'b0);
            scan_dr((3'(op) == OP_SAMPLE || 3'(op) == OP_EXTEST) ? BSR_LEN : 1,
                    pat, 3'(op) == OP_SAMPLE);
            finish_batch("opcode");
            `CHK(extest_active, 3'(op) == OP_EXTEST)
            if (3'(op) == OP_EXTEST)
                `CHK(pin_out, pat)
            if (3'(op) == OP_SAMPLE) begin
                `CHK(pin_out, core_out)
                pre = pat;
            end
        end
        `CHK(saw_full, 1'b1)
        // preloaded pattern appears once external test is chosen
        scan_ir(OP_EXTEST, 1'b0);
        finish_batch("preload");
        `CHK(pin_out, pre)
        // scans refused while configuring, allowed with port support off
        config_busy <= 1'b1;
        scan_ir(OP_SAMPLE, 1'b1);
        finish_batch("config bar");
        `CHK(extest_active, 1'b0)
        config_busy <= 1'b0;
        push(CMD_RESET, 3'h0);
        finish_batch("recover");
        scan_off_user <= 1'b1;
        config_busy <= 1'b1;
        scan_ir(OP_EXTEST, 1'b0);
        finish_batch("user mode");
        `CHK(extest_active, 1'b1)
        tally_and_finish();
    end
endmodule
